// ### verilog/hsrc_defines.vh
// Constants for the haptic slot repeat-count sequencer block
// How it works
// - Field values 0-3 mean 1-4 plays
// - Slots 1,2 at bits 1-0,3-2 of slot_repeat_counts_low
// - Slots 3,4 at bits 5-4,7-6 of slot_repeat_counts_low
// - Slots 5,6 at bits 1-0,3-2 of slot_repeat_counts_high
// - Slots 7,8 at bits 5-4,7-6 of slot_repeat_counts_high
// - Finish all repeats before next slot
// - Repeat fields read/write, reset to zero
// - Play in order, stop at zero or eight
// - Wait flag means 10 ms per count
// - Main loop 0-6 extra passes, 7 endless
`ifndef HSRC_DEFINES_VH
`define HSRC_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define HSRC_IDX_CTRL        6'h0C
`define HSRC_IDX_SLOT_FIRST  6'h0F
`define HSRC_IDX_SLOT_LAST   6'h16
`define HSRC_IDX_REPEAT_LOW  6'h17
`define HSRC_IDX_REPEAT_HIGH 6'h18
`define HSRC_IDX_MAIN_LOOP   6'h19
`define HSRC_IDX_STATUS      6'h1F

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define HSRC_CTRL_GO_BIT     0
`define HSRC_SLOT_DELAY_BIT  7
`define HSRC_REPEAT_W        2
`define HSRC_LOOP_ENDLESS    3'h7
`define HSRC_RST_BYTE        8'h00
`define HSRC_RST_LOOP        3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HSRC_DELAY_UNIT_MS   10
`define HSRC_CLK_KHZ         200000

`endif

// ### verilog/hsrc_delay_timer.v
// Idle delay timer counting in 10 ms units
`timescale 1ns/1ps
`default_nettype none
`include "hsrc_defines.vh"

module hsrc_delay_timer
#(
  parameter UNIT_CYCLES = `HSRC_DELAY_UNIT_MS * `HSRC_CLK_KHZ
)
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       start,
  input  wire       abort,
  input  wire [6:0] units,
  output reg        done
);

  reg  [31:0] cyc_reg;
  reg  [6:0]  left_reg;
  reg         run_reg;

  wire unit_end = (cyc_reg == UNIT_CYCLES - 1);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_reg  <= 32'h0;
      left_reg <= 7'h00;
      run_reg  <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        run_reg <= 1'b0;
        cyc_reg <= 32'h0;
      end
      else if (start)
      begin
        run_reg  <= 1'b1;
        cyc_reg  <= 32'h0;
        left_reg <= units;
      end
      else if (run_reg)
      begin
        if (unit_end)
        begin
          cyc_reg <= 32'h0;
          if (left_reg == 7'h01)
          begin
            run_reg <= 1'b0;
            done    <= 1'b1;
          end
          left_reg <= left_reg - 7'h01;
        end
        else
          cyc_reg <= cyc_reg + 32'h1;
      end
    end
  end

endmodule // hsrc_delay_timer
`default_nettype wire

// ### verilog/hsrc_top.v
// APB register bank and slot walker with per-slot repeat counts
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hsrc_defines.vh"

module hsrc_top
#(
  parameter UNIT_CYCLES = `HSRC_DELAY_UNIT_MS * `HSRC_CLK_KHZ
)
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Playback engine
  input  wire        effect_done,
  output reg         effect_start,
  output reg  [6:0]  effect_id,
  output reg         effect_abort,
  output reg         busy,
  // External stop trigger pin
  input  wire        stop_pin
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_CHECK = 4'h2;
  localparam [3:0] ST_PLAY  = 4'h4;
  localparam [3:0] ST_DELAY = 4'h8;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  [7:0]  slot_reg [0:7];
  reg  [7:0]  repeat_low_reg;
  reg  [7:0]  repeat_high_reg;
  reg  [2:0]  main_loop_reg;
  reg         go_reg;
  reg  [3:0]  state_reg;
  reg  [2:0]  slot_idx_reg;
  reg  [1:0]  rep_cnt_reg;
  reg  [2:0]  pass_cnt_reg;
  reg  [2:0]  stop_sync_reg;

  wire [5:0]  idx       = paddr[7:2];
  wire        apb_done  = psel & penable & pready;
  wire        wr_go     = apb_done & pwrite & (idx == `HSRC_IDX_CTRL);
  wire        trig_stop = stop_sync_reg[1] & ~stop_sync_reg[2];
  wire        timer_done;

  // --------------------------------------------------------------------
  // Slot walker decode
  // --------------------------------------------------------------------
  wire [15:0] repeat_all = {repeat_high_reg, repeat_low_reg};
  wire [1:0]  cur_repeat = repeat_all[{slot_idx_reg, 1'b0} +: `HSRC_REPEAT_W];
  wire [7:0]  cur_slot   = slot_reg[slot_idx_reg];
  wire        cur_zero   = (cur_slot[6:0] == 7'h00);
  wire        cur_delay  = cur_slot[`HSRC_SLOT_DELAY_BIT];
  wire        entry_end  = (state_reg == ST_PLAY & effect_done)
                         | (state_reg == ST_DELAY & timer_done);
  wire        more_reps  = (rep_cnt_reg != cur_repeat);
  wire        more_pass  = (main_loop_reg == `HSRC_LOOP_ENDLESS)
                         | (pass_cnt_reg != main_loop_reg);
  wire        stop_now   = busy & (~go_reg | trig_stop);
  wire        start_now  = (state_reg == ST_IDLE) & go_reg;
  wire        pass_end   = (state_reg == ST_CHECK & cur_zero)
                         | (entry_end & ~more_reps & slot_idx_reg == 3'h7);
  wire        finish     = pass_end & ~more_pass;
  wire        timer_go   = (state_reg == ST_CHECK) & ~cur_zero & cur_delay & ~stop_now;

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_slot
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          slot_reg[g] <= `HSRC_RST_BYTE;
        else if (apb_done & pwrite & (idx == `HSRC_IDX_SLOT_FIRST + g))
          slot_reg[g] <= pwdata[7:0];
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      repeat_low_reg  <= `HSRC_RST_BYTE;
      repeat_high_reg <= `HSRC_RST_BYTE;
      main_loop_reg   <= `HSRC_RST_LOOP;
      go_reg          <= 1'b0;
      stop_sync_reg   <= 3'h0;
    end
    else
    begin
      stop_sync_reg <= {stop_sync_reg[1:0], stop_pin};
      if (apb_done & pwrite & (idx == `HSRC_IDX_REPEAT_LOW))
        repeat_low_reg <= pwdata[7:0];
      if (apb_done & pwrite & (idx == `HSRC_IDX_REPEAT_HIGH))
        repeat_high_reg <= pwdata[7:0];
      if (apb_done & pwrite & (idx == `HSRC_IDX_MAIN_LOOP))
        main_loop_reg <= pwdata[2:0];
      // Software set beats a same-cycle hardware clear
      if (wr_go)
        go_reg <= pwdata[`HSRC_CTRL_GO_BIT];
      else if (finish | (busy & trig_stop))
        go_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Slot walker
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= ST_IDLE;
      slot_idx_reg <= 3'h0;
      rep_cnt_reg  <= 2'h0;
      pass_cnt_reg <= 3'h0;
      busy         <= 1'b0;
      effect_start <= 1'b0;
      effect_id    <= 7'h00;
      effect_abort <= 1'b0;
    end
    else
    begin
      effect_start <= 1'b0;
      effect_abort <= 1'b0;
      if (stop_now)
      begin
        state_reg    <= ST_IDLE;
        busy         <= 1'b0;
        rep_cnt_reg  <= 2'h0;
        effect_abort <= 1'b1;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (start_now)
            begin
              state_reg    <= ST_CHECK;
              busy         <= 1'b1;
              slot_idx_reg <= 3'h0;
              rep_cnt_reg  <= 2'h0;
              pass_cnt_reg <= 3'h0;
            end
          end
          ST_CHECK:
          begin
            if (cur_zero)
              state_reg <= ST_CHECK; // pass end handled below
            else if (cur_delay)
              state_reg <= ST_DELAY;
            else
            begin
              state_reg    <= ST_PLAY;
              effect_start <= 1'b1;
              effect_id    <= cur_slot[6:0];
            end
          end
          ST_PLAY, ST_DELAY:
          begin
            if (entry_end & more_reps)
            begin
              rep_cnt_reg <= rep_cnt_reg + 2'h1;
              state_reg   <= ST_CHECK;
            end
            else if (entry_end & slot_idx_reg != 3'h7)
            begin
              slot_idx_reg <= slot_idx_reg + 3'h1;
              rep_cnt_reg  <= 2'h0;
              state_reg    <= ST_CHECK;
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
        if (pass_end)
        begin
          rep_cnt_reg  <= 2'h0;
          slot_idx_reg <= 3'h0;
          if (more_pass)
          begin
            state_reg <= ST_CHECK;
            if (main_loop_reg != `HSRC_LOOP_ENDLESS)
              pass_cnt_reg <= pass_cnt_reg + 3'h1;
          end
          else
          begin
            state_reg <= ST_IDLE;
            busy      <= 1'b0;
          end
        end
      end
    end
  end

  hsrc_delay_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) hsrc_delay_timer_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_go),
    .abort   (stop_now),
    .units   (cur_slot[6:0]),
    .done    (timer_done)
  );

  // --------------------------------------------------------------------
  // APB read and handshake, one wait state
  // --------------------------------------------------------------------
  reg [31:0] rd_next;
  reg        err_next;

  always @*
  begin
    rd_next  = 32'h0;
    err_next = 1'b0;
    if (idx >= `HSRC_IDX_SLOT_FIRST && idx <= `HSRC_IDX_SLOT_LAST)
      rd_next = {24'h0, slot_reg[idx[2:0] - 3'h7]};
    else
    begin
      case (idx)
        `HSRC_IDX_CTRL:        rd_next = {31'h0, go_reg};
        `HSRC_IDX_REPEAT_LOW:  rd_next = {24'h0, repeat_low_reg};
        `HSRC_IDX_REPEAT_HIGH: rd_next = {24'h0, repeat_high_reg};
        `HSRC_IDX_MAIN_LOOP:   rd_next = {29'h0, main_loop_reg};
        `HSRC_IDX_STATUS:
          rd_next = {23'h0, pass_cnt_reg, rep_cnt_reg, slot_idx_reg, busy};
        default:               err_next = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_next;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_next;
    end
  end

endmodule // hsrc_top
`default_nettype wire

// ### verification/hsrc_asserts.sv
// Port checker for the slot repeat-count sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hsrc_defines.vh"
module hsrc_asserts (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Playback engine
  input wire logic        effect_done,
  input wire logic        effect_start,
  input wire logic [6:0]  effect_id,
  input wire logic        effect_abort,
  input wire logic        busy,
  input wire logic        stop_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR_READ_ZERO: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error reply");
  // Status is the only register with a bit above the low byte
  AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:9] == 23'h0
    && (paddr[7:2] == `HSRC_IDX_STATUS || !prdata[8]))
    else $error("upper read bits set");
  AST_START_PULSE: assert property (effect_start |=> !effect_start)
    else $error("start not a pulse");
  AST_START_BUSY: assert property (effect_start |-> busy)
    else $error("start while idle");
  AST_ID_HOLD: assert property ($changed(effect_id) |-> effect_start)
    else $error("id moved without start");
  AST_GO_BUSY: assert property (psel && penable && pready && pwrite && !busy
    && paddr[7:2] == `HSRC_IDX_CTRL && pwdata[`HSRC_CTRL_GO_BIT] |-> ##2 busy)
    else $error("go did not start");
  AST_ABORT_IDLE: assert property (effect_abort |=> !busy && !effect_abort)
    else $error("abort left busy");

  cover property (effect_abort);
  cover property (pslverr);
  cover property (effect_start ##[1:200] effect_start);
endmodule // hsrc_asserts

bind hsrc_top hsrc_asserts hsrc_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .effect_done(effect_done),
  .effect_start(effect_start), .effect_id(effect_id), .effect_abort(effect_abort),
  .busy(busy), .stop_pin(stop_pin));
`default_nettype wire

// ### verification/hsrc_tb.sv
// Self-checking bench for the slot repeat-count sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hsrc_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module hsrc_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        effect_done = 0, stop_pin = 0, er, ab;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, effect_start, effect_abort, busy;
  wire logic [6:0]  effect_id;
  int          err_count = 0, n_tests = 0, cnt[128], nst, sw, t9, t10, e;

  // Short delay unit keeps the run brief
  hsrc_top #(.UNIT_CYCLES(20)) hsrc_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .effect_done(effect_done),
    .effect_start(effect_start), .effect_id(effect_id), .effect_abort(effect_abort),
    .busy(busy), .stop_pin(stop_pin));

  initial forever #2.5 pclk = ~pclk;

  task results;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // ----
  // Bus and engine helpers
  // ----
  task apb(input logic w, input logic [5:0] ix, input logic [31:0] d);
  begin
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the bench timeout ends a wait for the slave
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle cycle so back-to-back calls never drive psel twice in one step
    @(posedge pclk);
  end
  endtask

  // Answers each start with a done pulse; returns when busy drops or at lim
  task run(input int lim);
    int dly, c, pv;
    logic seen;
  begin
    dly = 0; seen = 0; nst = 0; sw = 0; pv = -1; t9 = 0; t10 = 0;
    foreach (cnt[i]) cnt[i] = 0;
    for (c = 1; c < lim; c++)
    begin
      @(posedge pclk);
      effect_done <= (dly == 1);
      if (dly > 0) dly--;
      if (busy === 1'b1) seen = 1;
      if (effect_start === 1'b1)
      begin
        cnt[effect_id]++;
        nst++;
        dly = 3;
        if (pv != -1 && pv != effect_id) sw++;
        pv = effect_id;
        if (effect_id == 9 && t9 == 0) t9 = c;
        if (effect_id == 10 && t10 == 0) t10 = c;
      end
      if (seen && busy !== 1'b1) break;
    end
    @(posedge pclk);
    effect_done <= 0;
  end
  endtask

  task wait_abort;
  begin
    ab = 0;
    for (int k = 0; k < 10; k++)
    begin
      @(posedge pclk);
      stop_pin <= 0;
      if (effect_abort === 1'b1) ab = 1;
    end
  end
  endtask

  // ----
  // Scenarios
  // ----
  task t_regs;
  begin
    apb(0, `HSRC_IDX_REPEAT_LOW, 0);
    `CHK("low reset", 32'h0, rd)
    apb(0, `HSRC_IDX_REPEAT_HIGH, 0);
    `CHK("high reset", 32'h0, rd)
    apb(1, `HSRC_IDX_REPEAT_LOW, 32'hFFFF_FFE4);
    apb(0, `HSRC_IDX_REPEAT_LOW, 0);
    `CHK("low rw", 32'hE4, rd)
    apb(1, `HSRC_IDX_REPEAT_HIGH, 32'h1B);
    apb(0, `HSRC_IDX_REPEAT_HIGH, 0);
    `CHK("high rw", 32'h1B, rd)
    apb(0, 6'h3E, 0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("end t_regs");
  end
  endtask

  // Slot s plays id s+1; fields 0,1,2,3,3,2,1,0 give 1..4 plays each
  task t_repeat;
  begin
    for (int s = 0; s < 8; s++) apb(1, `HSRC_IDX_SLOT_FIRST + s, s + 1);
    apb(1, `HSRC_IDX_CTRL, 1);
    run(2000);
    for (int s = 0; s < 8; s++)
    begin
      e = (((s < 4 ? 8'hE4 : 8'h1B) >> (2 * (s % 4))) & 3) + 1;
      `CHK("plays", e, cnt[s + 1])
    end
    `CHK("slot changes", 7, sw)
    `CHK("busy end", 1'b0, busy)
    $display("end t_repeat");
  end
  endtask

  // Delay slot played twice between two waveforms, whole pass looped once
  task t_delay;
  begin
    apb(1, `HSRC_IDX_SLOT_FIRST, 9);
    apb(1, `HSRC_IDX_SLOT_FIRST + 1, 8'h82);
    apb(1, `HSRC_IDX_SLOT_FIRST + 2, 10);
    apb(1, `HSRC_IDX_SLOT_FIRST + 3, 0);
    apb(1, `HSRC_IDX_REPEAT_LOW, 32'h04);
    apb(1, `HSRC_IDX_REPEAT_HIGH, 0);
    apb(1, `HSRC_IDX_MAIN_LOOP, 1);
    apb(1, `HSRC_IDX_CTRL, 1);
    run(3000);
    `CHK("id9 plays", 2, cnt[9])
    `CHK("id10 plays", 2, cnt[10])
    `CHK("switches", 3, sw)
    `CHK("delay gap", 1'b1, (t10 - t9 >= 80) && (t10 - t9 <= 100))
    apb(0, `HSRC_IDX_SLOT_FIRST + 1, 0);
    `CHK("slot rd", 32'h82, rd)
    apb(0, `HSRC_IDX_MAIN_LOOP, 0);
    `CHK("loop rd", 32'h1, rd)
    $display("end t_delay");
  end
  endtask

  // Endless loop stopped by go and by the stop pin
  task t_stop;
  begin
    apb(1, `HSRC_IDX_MAIN_LOOP, 7);
    apb(1, `HSRC_IDX_CTRL, 1);
    // Length puts the stop inside the second wait of slot two
    run(460);
    `CHK("endless busy", 1'b1, busy)
    `CHK("looped", 1'b1, nst > 4)
    apb(0, `HSRC_IDX_STATUS, 0);
    `CHK("count mid", 2'b01, rd[5:4])
    apb(1, `HSRC_IDX_CTRL, 0);
    wait_abort;
    `CHK("go abort", 1'b1, ab)
    `CHK("go idle", 1'b0, busy)
    apb(0, `HSRC_IDX_STATUS, 0);
    `CHK("count cleared", 2'b00, rd[5:4])
    apb(1, `HSRC_IDX_CTRL, 1);
    run(60);
    stop_pin <= 1;
    wait_abort;
    `CHK("pin abort", 1'b1, ab)
    `CHK("pin idle", 1'b0, busy)
    apb(0, `HSRC_IDX_CTRL, 0);
    `CHK("go cleared", 32'h0, rd)
    $display("end t_stop");
  end
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_repeat;
    t_delay;
    t_stop;
    results;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results;
  end
endmodule // hsrc_tb
`default_nettype wire
